// ### host_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_pin_model #(
  parameter int SETTLE_CYCLES = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pin driver of the device
  input wire logic int_out,
  input wire logic int_oe,
  // Host view
  output logic pin,
  output logic settled
);
  int cnt;
  // Board pull-up: an undriven or open-drain pin reads high
  assign pin = int_oe ? int_out : 1'b1;
  // Host trusts the pin only once the settle time has run out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 0;
      settled <= 1'b0;
    end else if (cnt < SETTLE_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      settled <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### rtc_irq_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Power and pin
  input wire logic on_backup,
  input wire logic int_out,
  input wire logic int_oe
);
  import rtc_irq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  property p_reset_idle;
    sys_rst |=> !int_oe && !int_out && !reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_read_answer;
    disable iff (sys_rst) reg_rd && !on_backup && !$past(sys_rst) |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_capture_refused;
    disable iff (sys_rst) reg_rd && $past(sys_rst) |=> !reg_rvalid;
  endproperty
  a_capture_refused: assert property (p_capture_refused) else $error("read taken in capture cycle");
  property p_backup_refused;
    disable iff (sys_rst) reg_rd && on_backup |=> !reg_rvalid;
  endproperty
  a_backup_refused: assert property (p_backup_refused) else $error("read taken on backup");
  property p_rvalid_cause;
    disable iff (sys_rst) reg_rvalid |-> $past(reg_rd) && !$past(on_backup);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without request");
  property p_rdata_hold;
    disable iff (sys_rst) !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without answer");
  property p_unmapped_zero;
    disable iff (sys_rst) reg_rd && !on_backup && !$past(sys_rst) && reg_addr != OFS_EVENT_FLAGS
      && reg_addr != OFS_INTERRUPT_CONTROL && reg_addr != OFS_WATCHDOG_CONTROL |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_kick_reads_zero;
    disable iff (sys_rst) reg_rd && !on_backup && reg_addr == OFS_WATCHDOG_CONTROL |=> !reg_rdata[WDC_KICK];
  endproperty
  a_kick_reads_zero: assert property (p_kick_reads_zero) else $error("kick bit read as one");
  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  property p_backup_quiet;
    disable iff (sys_rst) on_backup ##1 on_backup |-> !int_oe;
  endproperty
  a_backup_quiet: assert property (p_backup_quiet) else $error("pin driven on backup");
  property p_out_driven;
    disable iff (sys_rst) int_out |-> int_oe;
  endproperty
  a_out_driven: assert property (p_out_driven) else $error("pin level high while not driven");
endmodule
`default_nettype wire

// ### rtc_irq_pkg.sv
package rtc_irq_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_EVENT_FLAGS = 4'h0;
  localparam logic [3:0] OFS_INTERRUPT_CONTROL = 4'h6;
  localparam logic [3:0] OFS_WATCHDOG_CONTROL = 4'h7;

  // ------------------------------------------------------------
  // Flags field positions
  // ------------------------------------------------------------
  localparam int FLG_WATCHDOG = 7;
  localparam int FLG_ALARM = 6;
  localparam int FLG_POWER_FAIL = 5;
  localparam int FLG_OSC_STOPPED = 4;
  localparam int FLG_BACKUP_LOST = 3;
  localparam int FLG_CAL_OUT = 2;
  localparam int FLG_UPDATE_UNLOCK = 1;

  // ------------------------------------------------------------
  // Interrupt control field positions
  // ------------------------------------------------------------
  localparam int ICT_WATCHDOG_EN = 7;
  localparam int ICT_ALARM_EN = 6;
  localparam int ICT_POWERFAIL_EN = 5;
  localparam int ICT_WAVE_EN = 4;
  localparam int ICT_ACTIVE_HIGH = 3;
  localparam int ICT_PULSE_MODE = 2;
  localparam int ICT_FREQ_HI = 1;
  localparam int ICT_FREQ_LO = 0;

  // ------------------------------------------------------------
  // Watchdog control field positions
  // ------------------------------------------------------------
  localparam int WDC_KICK = 7;
  localparam int WDC_LOCK = 6;
  localparam int WDC_TIMEOUT_MSB = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h08;
  localparam logic [5:0] RST_TIMEOUT = 6'h00;
  localparam logic [14:0] RST_DIVIDER = 15'h0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int XTAL_HZ = 32768;
  localparam int WATCHDOG_TICK_HZ = 32;
  localparam int TICK_DIV = XTAL_HZ / WATCHDOG_TICK_HZ;
  localparam logic [9:0] TICK_LAST = 10'(TICK_DIV - 1);
  localparam int PULSE_MS = 200;
  localparam int PULSE_XTAL_CYCLES = (PULSE_MS * XTAL_HZ) / 1000;

  // ------------------------------------------------------------
  // Power-up sequencing
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } boot_state_e;

endpackage

// ### rtc_watchdog_interrupt_output.sv
// Summary of operation
// - Watchdog counter decrements once per 32 Hz tick; stalls while oscillator stopped.
// - At power-up the stored timeout loads the counter and counting starts.
// - Writing one to the kick bit reloads the counter and restarts countdown.
// - Counter reaching zero sets the expired flag and may request interrupt.
// - Timeout field writes accepted only when the lock bit written with them is zero.
// - Timeout value zero disables the watchdog entirely.
// - Watchdog enable routes timeout to the pin; flags read clears both.
// - Alarm or power-fail enable at zero only sets the flag.
// - Frequency select: 00 1 Hz, 01 512 Hz, 10 4096 Hz, 11 32768 Hz.
// - Wave enable and frequency bits restored from nonvolatile storage at power-up.
// - No square wave and no interrupt while on backup power.
// - Host register access blocked on backup; timekeeping keeps running.
// - Backup voltage failure sets backup-lost flag at next power-up.
// - Interrupt only when a flag and its enable bit are both set.
// - Pulse mode drives the pin active about 200 ms per interrupt.
// - Level mode holds the pin active until the flags register is read.
// - Polarity one: active high, push-pull for calibration and square wave, released while no source is active; zero: active low open drain.
// - Pin priority: calibration, square wave, interrupts; otherwise high impedance.
// - Flags read clears watchdog, alarm, power-fail and backup-lost flags and returns pin inactive, cutting pulses short.
// - Power-up clears flags except oscillator-stopped and backup-lost, which take their detected state.
// - Watchdog, alarm and power-fail events set their flags for polling.
// - Calibration output bit toggles the pin at nominal 512 Hz.
// - Flag changes staged under unlock bit; applied when it returns to zero.
// - Alarm match from the comparator sets the alarm match flag.
`timescale 1ns/1ps
`default_nettype none
module rtc_watchdog_interrupt_output
  import rtc_irq_pkg::*;
#(
  parameter int PULSE_CYCLES = rtc_irq_pkg::PULSE_XTAL_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Oscillator and power monitors
  input wire logic xtal_in,
  input wire logic main_fail,
  input wire logic on_backup,
  // Power-up state
  input wire logic [7:0] nv_interrupt_control,
  input wire logic [5:0] nv_timeout,
  input wire logic osc_failed_at_powerup,
  input wire logic backup_failed_at_powerup,
  // Alarm comparator
  input wire logic alarm_match,
  // Interrupt pin
  output logic int_out,
  output logic int_oe
);

  // ------------------------------------------------------------
  // Divider taps
  // ------------------------------------------------------------
  xtal_tick_if taps ();

  xtal_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .xtal_in(xtal_in),
    .taps(taps)
  );

  function automatic logic wave_of(input logic [1:0] sel, input logic [14:0] d, input logic x);
    logic r;
    r = 1'b0;
    unique case (sel)
      2'b00: r = d[14];
      2'b01: r = d[5];
      2'b10: r = d[2];
      2'b11: r = x;
    endcase
    return r;
  endfunction

  wire logic tick32 = taps.xtal_edge && (taps.div[9:0] == TICK_LAST);

  // ------------------------------------------------------------
  // Power-up capture
  // ------------------------------------------------------------
  boot_state_e state;
  wire logic capture = state == ST_CAPTURE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_CAPTURE;
    end else begin
      unique case (state)
        ST_CAPTURE: state <= ST_RUN;
        ST_RUN: state <= ST_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Main supply fail synchroniser
  // ------------------------------------------------------------
  logic [2:0] pf_sync;
  logic pf_level;
  wire logic pf_agree = pf_sync[1] == pf_sync[2];
  wire logic pf_event = pf_agree && pf_sync[2] && !pf_level;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pf_sync <= 3'h0;
      pf_level <= 1'b0;
    end else begin
      pf_sync <= {pf_sync[1:0], main_fail};
      if (pf_agree) begin
        pf_level <= pf_sync[2];
      end
    end
  end

  // ------------------------------------------------------------
  // Register port decode
  // ------------------------------------------------------------
  wire logic host_ok = !on_backup && !capture;
  wire logic wr_ok = reg_wr && host_ok;
  wire logic rd_ok = reg_rd && host_ok;
  wire logic wr_flags = wr_ok && (reg_addr == OFS_EVENT_FLAGS);
  wire logic wr_ictl = wr_ok && (reg_addr == OFS_INTERRUPT_CONTROL);
  wire logic wr_wdc = wr_ok && (reg_addr == OFS_WATCHDOG_CONTROL);
  wire logic rd_flags = rd_ok && (reg_addr == OFS_EVENT_FLAGS);

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [7:0] ictl;
  logic lock;
  logic [5:0] timeout;
  wire logic kick = wr_wdc && reg_wdata[WDC_KICK];
  wire logic take_timeout = wr_wdc && !reg_wdata[WDC_LOCK];
  wire logic [5:0] next_timeout = take_timeout ? reg_wdata[WDC_TIMEOUT_MSB:0] : timeout;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ictl <= RST_INTERRUPT_CONTROL;
      lock <= 1'b0;
      timeout <= RST_TIMEOUT;
    end else if (capture) begin
      ictl <= nv_interrupt_control;
      timeout <= nv_timeout;
    end else begin
      if (wr_ictl) begin
        ictl <= reg_wdata;
      end
      if (wr_wdc) begin
        lock <= reg_wdata[WDC_LOCK];
      end
      timeout <= next_timeout;
    end
  end

  // ------------------------------------------------------------
  // Watchdog counter
  // ------------------------------------------------------------
  logic [5:0] count;
  logic load_pending;
  wire logic wd_live = timeout != 6'h00;
  wire logic wd_expire = wd_live && !load_pending && !kick && tick32 && (count == 6'h01);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= RST_TIMEOUT;
      load_pending <= 1'b1;
    end else if (capture) begin
      load_pending <= 1'b1;
    end else if (load_pending || kick) begin
      count <= next_timeout;
      load_pending <= 1'b0;
    end else if (tick32 && wd_live) begin
      // Free running: expiry reloads so the next period starts at once
      count <= (count <= 6'h01) ? timeout : count - 6'h01;
    end
  end

  // ------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------
  logic flag_wd, flag_alarm, flag_pf, flag_osc, flag_bpf, flag_cal, unlock;
  logic stage_cal, stage_osc, stage_bpf;
  wire logic apply_flags = wr_flags && unlock && !reg_wdata[FLG_UPDATE_UNLOCK];

  // Events win over a same-cycle read clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_wd <= RST_EVENT_FLAGS[FLG_WATCHDOG];
      flag_alarm <= RST_EVENT_FLAGS[FLG_ALARM];
      flag_pf <= RST_EVENT_FLAGS[FLG_POWER_FAIL];
      flag_osc <= RST_EVENT_FLAGS[FLG_OSC_STOPPED];
      flag_bpf <= RST_EVENT_FLAGS[FLG_BACKUP_LOST];
    end else if (capture) begin
      flag_osc <= osc_failed_at_powerup;
      flag_bpf <= backup_failed_at_powerup;
    end else begin
      flag_wd <= wd_expire || (flag_wd && !rd_flags);
      flag_alarm <= alarm_match || (flag_alarm && !rd_flags);
      flag_pf <= pf_event || (flag_pf && !rd_flags);
      if (apply_flags) begin
        flag_osc <= stage_osc;
        flag_bpf <= stage_bpf && !rd_flags;
      end else if (rd_flags) begin
        flag_bpf <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_cal <= RST_EVENT_FLAGS[FLG_CAL_OUT];
      unlock <= RST_EVENT_FLAGS[FLG_UPDATE_UNLOCK];
      stage_cal <= 1'b0;
      stage_osc <= 1'b0;
      stage_bpf <= 1'b0;
    end else if (wr_flags) begin
      unlock <= reg_wdata[FLG_UPDATE_UNLOCK];
      if (reg_wdata[FLG_UPDATE_UNLOCK]) begin
        stage_cal <= reg_wdata[FLG_CAL_OUT];
        stage_osc <= reg_wdata[FLG_OSC_STOPPED];
        stage_bpf <= reg_wdata[FLG_BACKUP_LOST];
      end
      if (apply_flags) begin
        flag_cal <= stage_cal;
      end
    end
  end

  wire logic [7:0] flags_word = {flag_wd, flag_alarm, flag_pf, flag_osc, flag_bpf, flag_cal, unlock, 1'b0};

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  wire logic [7:0] rd_mux = (reg_addr == OFS_EVENT_FLAGS) ? flags_word :
                            (reg_addr == OFS_INTERRUPT_CONTROL) ? ictl :
                            (reg_addr == OFS_WATCHDOG_CONTROL) ? {1'b0, lock, timeout} : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_ok;
      if (rd_ok) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt combiner
  // ------------------------------------------------------------
  wire logic req_wd = flag_wd && ictl[ICT_WATCHDOG_EN];
  wire logic req_alarm = flag_alarm && ictl[ICT_ALARM_EN];
  wire logic req_pf = flag_pf && ictl[ICT_POWERFAIL_EN];
  wire logic irq_req = (req_wd || req_alarm || req_pf) && !on_backup;
  logic irq_prev;
  logic [15:0] pulse_left;
  wire logic irq_rise = irq_req && !irq_prev;
  wire logic pulse_mode = ictl[ICT_PULSE_MODE];
  wire logic pulse_run = pulse_left != 16'h0000;

  // Pulse stretches past the flag but dies on a flags read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_prev <= 1'b0;
      pulse_left <= 16'h0000;
    end else begin
      irq_prev <= irq_req;
      if (rd_flags || !pulse_mode || on_backup) begin
        pulse_left <= 16'h0000;
      end else if (irq_rise) begin
        pulse_left <= 16'(PULSE_CYCLES);
      end else if (pulse_run && taps.xtal_edge) begin
        pulse_left <= pulse_left - 16'h0001;
      end
    end
  end

  wire logic irq_active = pulse_mode ? pulse_run : irq_req;

  // ------------------------------------------------------------
  // Pin driver
  // ------------------------------------------------------------
  wire logic active_high = ictl[ICT_ACTIVE_HIGH];
  wire logic cal_sel = flag_cal && !on_backup;
  wire logic wave_sel = ictl[ICT_WAVE_EN] && !on_backup;
  wire logic wave = wave_of(ictl[ICT_FREQ_HI:ICT_FREQ_LO], taps.div, taps.xtal_level);
  wire logic osc_src = cal_sel ? taps.div[5] : wave;
  logic next_out, next_oe;

  always_comb begin
    next_out = 1'b0;
    next_oe = 1'b0;
    if (cal_sel || wave_sel) begin
      next_out = active_high && osc_src;
      next_oe = active_high || !osc_src;
    end else if (irq_active) begin
      next_out = active_high;
      next_oe = 1'b1;
    end
  end

  // Pin drive of either polarity only while not on backup power
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_out <= 1'b0;
      int_oe <= 1'b0;
    end else begin
      int_out <= next_out && !on_backup;
      int_oe <= next_oe && !on_backup;
    end
  end

endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
  import rtc_irq_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid, xtal_in, main_fail, on_backup, osc_f, backup_lost_flag;
  logic alarm_match, int_out, int_oe, pin, settled, xtal_run, ok;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, nv_ic, d;
  logic [5:0] nv_to;
  int error_cnt, checks, cyc, xdiv, c, k;
  int lo [4] = '{0, 3, 30, 250};
  int hi [4] = '{1, 5, 34, 258};
  wire logic act_hi = int_oe & int_out;
  rtc_watchdog_interrupt_output #(.PULSE_CYCLES(4)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .xtal_in(xtal_in), .main_fail(main_fail), .on_backup(on_backup),
    .nv_interrupt_control(nv_ic), .nv_timeout(nv_to), .osc_failed_at_powerup(osc_f),
    .backup_failed_at_powerup(backup_lost_flag), .alarm_match(alarm_match), .int_out(int_out), .int_oe(int_oe));
  host_pin_model #(.SETTLE_CYCLES(16)) i_host (.clk(clk), .sys_rst(sys_rst), .int_out(int_out),
    .int_oe(int_oe), .pin(pin), .settled(settled));
  always #2 clk = ~clk;
  // Crystal runs far above 32768 Hz so a watchdog tick is 8192 clocks
  always @(negedge clk) begin
    if (xtal_run && xdiv == 3) begin
      xdiv <= 0;
      xtal_in <= ~xtal_in;
    end else if (xtal_run) begin
      xdiv <= xdiv + 1;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: run too long", $time);
      results();
    end
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    repeat (3) begin
      if (reg_rvalid === 1'b1 && !ok) begin
        ok = 1'b1;
        d = reg_rdata;
      end
      @(negedge clk);
    end
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    rd(a);
    `CHK(ok, 1'b1)
    `CHK(d & m, e)
  endtask
  task automatic wait_on(input int n);
    for (int i = 0; i < n && act_hi !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic alarm;
    @(negedge clk);
    alarm_match = 1'b1;
    @(negedge clk);
    alarm_match = 1'b0;
  endtask
  task automatic changes(input int n);
    logic last;
    c = 0;
    last = pin;
    repeat (n) begin
      @(negedge clk);
      if (pin !== last) c++;
      last = pin;
    end
  endtask
  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    {clk, reg_wr, reg_rd, xtal_in, main_fail, on_backup, alarm_match, xdiv, cyc} = '0;
    {error_cnt, checks} = '0;
    {sys_rst, xtal_run, osc_f, backup_lost_flag} = 4'hF;
    {reg_addr, reg_wdata, nv_ic, nv_to} = {4'h0, 8'h00, 8'h03, 6'h03};
    repeat (12) @(negedge clk);
    // A read in the capture cycle is refused, so it must not clear the backup-lost flag
    sys_rst = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b0)
    while (settled !== 1'b1) @(negedge clk);
    chk_rd(OFS_EVENT_FLAGS, 8'h18, 8'hFF);
    chk_rd(OFS_EVENT_FLAGS, 8'h10, 8'hFF);
    chk_rd(OFS_INTERRUPT_CONTROL, 8'h03, 8'hFF);
    chk_rd(OFS_WATCHDOG_CONTROL, 8'h03, 8'h3F);
    chk_rd(4'h3, 8'h00, 8'hFF);
    wr(OFS_EVENT_FLAGS, 8'h02);
    wr(OFS_EVENT_FLAGS, 8'h00);
    chk_rd(OFS_EVENT_FLAGS, 8'h00, 8'hFF);
    wr(OFS_WATCHDOG_CONTROL, 8'h45);
    chk_rd(OFS_WATCHDOG_CONTROL, 8'h03, 8'h3F);
    tdone("registers");
    wr(OFS_WATCHDOG_CONTROL, 8'h82);
    wr(OFS_INTERRUPT_CONTROL, 8'h88);
    repeat (4) begin
      repeat (6000) @(negedge clk);
      wr(OFS_WATCHDOG_CONTROL, 8'hC0);
    end
    `CHK(act_hi, 1'b0)
    chk_rd(OFS_EVENT_FLAGS, 8'h00, 8'hFF);
    // Stop the crystal before the kick so no edge still in the synchroniser can tick afterwards
    xtal_run = 1'b0;
    repeat (8) @(negedge clk);
    wr(OFS_WATCHDOG_CONTROL, 8'h81);
    repeat (12000) @(negedge clk);
    chk_rd(OFS_EVENT_FLAGS, 8'h00, 8'hFF);
    xtal_run = 1'b1;
    wait_on(20000);
    `CHK(act_hi, 1'b1)
    chk_rd(OFS_EVENT_FLAGS, 8'h80, 8'hFF);
    `CHK(act_hi, 1'b0)
    wr(OFS_WATCHDOG_CONTROL, 8'h80);
    rd(OFS_EVENT_FLAGS);
    repeat (18000) @(negedge clk);
    chk_rd(OFS_EVENT_FLAGS, 8'h00, 8'hFF);
    tdone("watchdog");
    wr(OFS_INTERRUPT_CONTROL, 8'h08);
    alarm();
    repeat (10) @(negedge clk);
    `CHK(int_oe, 1'b0)
    chk_rd(OFS_EVENT_FLAGS, 8'h40, 8'hFF);
    wr(OFS_INTERRUPT_CONTROL, 8'h40);
    alarm();
    repeat (10) @(negedge clk);
    `CHK({int_oe, pin}, 2'b10)
    repeat (100) @(negedge clk);
    `CHK(pin, 1'b0)
    chk_rd(OFS_EVENT_FLAGS, 8'h40, 8'hFF);
    `CHK(pin, 1'b1)
    wr(OFS_INTERRUPT_CONTROL, 8'h4C);
    alarm();
    wait_on(10);
    `CHK(act_hi, 1'b1)
    repeat (100) @(negedge clk);
    `CHK(act_hi, 1'b0)
    chk_rd(OFS_EVENT_FLAGS, 8'h40, 8'hFF);
    wr(OFS_INTERRUPT_CONTROL, 8'h2C);
    main_fail = 1'b1;
    wait_on(10);
    `CHK(act_hi, 1'b1)
    chk_rd(OFS_EVENT_FLAGS, 8'h20, 8'hFF);
    `CHK(act_hi, 1'b0)
    main_fail = 1'b0;
    tdone("interrupts");
    for (k = 0; k < 4; k++) begin
      wr(OFS_INTERRUPT_CONTROL, 8'h18 | 8'(k));
      changes(1024);
      `CHK(c >= lo[k] && c <= hi[k], 1'b1)
    end
    wr(OFS_EVENT_FLAGS, 8'h06);
    wr(OFS_EVENT_FLAGS, 8'h00);
    changes(1024);
    `CHK(c >= 3 && c <= 5, 1'b1)
    on_backup = 1'b1;
    repeat (2) @(negedge clk);
    changes(200);
    `CHK({int_oe, c == 0}, 2'b01)
    rd(OFS_EVENT_FLAGS);
    `CHK(ok, 1'b0)
    on_backup = 1'b0;
    chk_rd(OFS_EVENT_FLAGS, 8'h04, 8'hFF);
    wr(OFS_EVENT_FLAGS, 8'h02);
    wr(OFS_EVENT_FLAGS, 8'h00);
    wr(OFS_INTERRUPT_CONTROL, 8'h00);
    repeat (4) @(negedge clk);
    `CHK(int_oe, 1'b0)
    tdone("pin sources");
    results();
  end
endmodule
bind rtc_watchdog_interrupt_output rtc_irq_checker i_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .on_backup(on_backup), .int_out(int_out), .int_oe(int_oe));
`default_nettype wire

// ### xtal_divider.sv
`timescale 1ns/1ps
`default_nettype none
module xtal_divider
  import rtc_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Crystal oscillator output
  input wire logic xtal_in,
  // Divided taps
  xtal_tick_if.src taps
);

  // ------------------------------------------------------------
  // Synchroniser and edge qualification
  // ------------------------------------------------------------
  logic [2:0] sync;
  logic level;
  logic [14:0] div;
  wire logic agree = sync[1] == sync[2];
  wire logic rise = agree && sync[2] && !level;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync <= 3'h0;
      level <= 1'b0;
    end else begin
      sync <= {sync[1:0], xtal_in};
      if (agree) begin
        level <= sync[2];
      end
    end
  end

  // ------------------------------------------------------------
  // Ripple-free divider chain
  // ------------------------------------------------------------
  // A stopped crystal produces no edges, so every tap freezes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div <= RST_DIVIDER;
    end else if (rise) begin
      div <= div + 15'h0001;
    end
  end

  assign taps.xtal_edge = rise;
  assign taps.xtal_level = level;
  assign taps.div = div;

endmodule
`default_nettype wire

// ### xtal_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface xtal_tick_if;
  logic xtal_edge;
  logic xtal_level;
  logic [14:0] div;
  modport src (output xtal_edge, output xtal_level, output div);
  modport sink (input xtal_edge, input xtal_level, input div);
endinterface
`default_nettype wire
